// ===== rtl/wcs_cfg.svh
`ifndef WCS_CFG_SVH
`define WCS_CFG_SVH
// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define WCS_CLK_KHZ        20000
`define WCS_CEP_FAST_MS    32
`define WCS_CEP_SLOW_MS    250
`define WCS_BIT_US         500
`define WCS_CEP_FAST_CYC   (`WCS_CEP_FAST_MS * `WCS_CLK_KHZ)
`define WCS_CEP_SLOW_CYC   (`WCS_CEP_SLOW_MS * `WCS_CLK_KHZ)
`define WCS_BIT_CYC        ((`WCS_BIT_US * `WCS_CLK_KHZ) / 1000)
`define WCS_TMR_W          24
// ----------------------------------------------------------------------
// Packet headers and end-transfer reason codes
// ----------------------------------------------------------------------
`define WCS_HDR_END        8'h02
`define WCS_HDR_CEP        8'h03
`define WCS_RSN_UNKNOWN    8'h00
`define WCS_RSN_COMPLETE   8'h01
`define WCS_RSN_FAULT      8'h02
`define WCS_RSN_OVERTEMP   8'h03
`define WCS_RSN_OVERVOLT   8'h04
`define WCS_RSN_OVERCUR    8'h05
`define WCS_RSN_BATT_FAIL  8'h06
`define WCS_RSN_RECONFIG   8'h07
`define WCS_RSN_NO_RESP    8'h08
`define WCS_FRAME_BITS     5'd24
`endif

// ===== rtl/wcs_modtx.sv
`timescale 1ns/1ps
`include "wcs_cfg.svh"
// Serial load modulator: header, payload, xor check, LSB first
module wcs_modtx
  import wcs_pkg::*;
#(
  parameter int BIT_CYC = `WCS_BIT_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  wcs_pkt_if.mod   pk
);
  typedef struct packed {
    logic                   busy;
    logic                   done;
    logic                   mod_on;
    logic [23:0]            sh;
    logic [4:0]             bits;
    logic [`WCS_TMR_W-1:0]  div;
  } wcs_mod_st_t;
  wcs_mod_st_t st_q, st_d;
  // --------------------------------------------------------------------
  // Bit sequencer
  // --------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (!st_q.busy) begin
      // Requests while busy are never issued by the supervisor
      if (pk.req) begin
        st_d.busy   = 1'b1;
        st_d.sh     = {pk.hdr ^ pk.data, pk.data, pk.hdr};
        st_d.bits   = `WCS_FRAME_BITS;
        st_d.div    = '0;
        st_d.mod_on = pk.hdr[0];
      end
    end else if (st_q.div == `WCS_TMR_W'(BIT_CYC - 1)) begin
      st_d.div = '0;
      if (st_q.bits == 5'h01) begin
        st_d.busy   = 1'b0;
        st_d.done   = 1'b1;
        st_d.mod_on = 1'b0;
      end else begin
        st_d.bits   = st_q.bits - 5'h01;
        st_d.sh     = {1'b0, st_q.sh[23:1]};
        st_d.mod_on = st_q.sh[1];
      end
    end else begin
      st_d.div = st_q.div + `WCS_TMR_W'(1);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign pk.busy   = st_q.busy;
  assign pk.done   = st_q.done;
  assign pk.mod_on = st_q.mod_on;
  // switches only move inside a frame
  mod_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st_q.busy |-> !st_q.mod_on) else $error("switch closed outside frame");
endmodule : wcs_modtx

// ===== rtl/wcs_pkg.sv
package wcs_pkg;
  // Supervisor states
  typedef enum logic [2:0] {
    WCS_ST_START, WCS_ST_WAIT_TEMP, WCS_ST_CHARGE, WCS_ST_END_SEND, WCS_ST_OFF
  } wcs_state_t;
  // Temperature zones
  typedef enum logic [1:0] {WCS_Z_OUT, WCS_Z_COOL, WCS_Z_NORM, WCS_Z_WARM} wcs_zone_t;
  // Synchronised pin levels
  typedef struct packed {
    logic t1, t2, t3, t4;
    logic surge, rect_ok, ovp, converged, no_converge;
    logic ibat_low, taper, pre_to, fast_to;
    logic adapter, ctrl_hi, ctrl_lo, die_hot, limit_short;
    logic term_float, prof_mod;
  } wcs_pins_t;
endpackage : wcs_pkg

// ===== rtl/wcs_pkt_if.sv
`timescale 1ns/1ps
// Packet request from supervisor to modulator
interface wcs_pkt_if;
  logic       req;     // One-cycle request
  logic [7:0] hdr;     // Header byte
  logic [7:0] data;    // Payload byte
  logic       busy;    // Frame in progress
  logic       done;    // One-cycle frame end
  logic       mod_on;  // Switch drive
  modport src (output req, hdr, data, input busy, done, mod_on);
  modport mod (input req, hdr, data, output busy, done, mod_on);
endinterface : wcs_pkt_if

// ===== rtl/wcs_top.sv
`timescale 1ns/1ps
`include "wcs_cfg.svh"
module wcs_top
  import wcs_pkg::*;
#(
  parameter int CEP_FAST_CYC = `WCS_CEP_FAST_CYC,
  parameter int CEP_SLOW_CYC = `WCS_CEP_SLOW_CYC,
  parameter int BIT_CYC      = `WCS_BIT_CYC
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic temp_past_cold_limit,
  input  wire logic temp_past_cool_zone,
  input  wire logic temp_past_warm_zone,
  input  wire logic temp_past_hot_limit,
  input  wire logic rect_surge,
  input  wire logic rect_acceptable,
  input  wire logic input_overvoltage,
  input  wire logic rect_converged,
  input  wire logic rect_no_converge,
  input  wire logic ibat_below_term,
  input  wire logic taper_phase,
  input  wire logic precharge_timeout,
  input  wire logic fastcharge_timeout,
  input  wire logic adapter_present,
  input  wire logic ctrl_pin_high,
  input  wire logic ctrl_pin_low,
  input  wire logic die_overtemp,
  input  wire logic current_limit_short,
  input  wire logic term_pin_floating,
  input  wire logic profile_modified,
  input  wire logic [7:0] rect_error,
  output logic      charge_enable,
  output logic      current_limit_half,
  output logic      voltage_target_reduced,
  output logic      comm_current_clamp,
  output logic      output_high_z,
  output logic      charge_status_output_val,
  output logic      charge_status_output_oe,
  output logic      modulation_switch_a,
  output logic      modulation_switch_b,
  output logic [7:0] end_reason,
  output logic      end_reason_valid
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    wcs_pins_t              s1;        // First sync stage
    wcs_pins_t              s2;        // Second sync stage
    wcs_state_t             state;     // Supervisor state
    logic                   fast;      // Fast packet cadence
    logic [`WCS_TMR_W-1:0]  cnt;       // Packet interval timer
    logic [7:0]             reason;    // Latched end reason
    logic                   rsn_vld;   // Reason latched
    logic                   end_sent;  // End packet handed over
    logic                   chg_en;    // Charger output enable
    logic                   cur_half;  // Current derating
    logic                   v_red;     // Voltage derating
    logic                   hiz;       // Output parked
    logic                   req;       // Packet request pulse
    logic [7:0]             hdr;       // Packet header
    logic [7:0]             data;      // Packet payload
  } wcs_top_st_t;

  wcs_top_st_t st_q, st_d;  // Registered state and next value
  wcs_pins_t   pin_raw;     // Asynchronous pin levels
  wcs_pins_t   p;           // Synchronised pin levels
  wcs_zone_t   zone;        // Present temperature zone
  logic        in_win;      // Inside threshold one-four window
  logic        z_half;      // Zone asks for half current
  logic        z_vred;      // Zone asks for reduced voltage
  logic        active;      // Power transfer states
  logic        cep_due;     // Error packet interval elapsed
  logic [7:0]  cand;        // Candidate reason code
  logic        cand_vld;    // A termination condition is present

  wcs_pkt_if pk ();

  // ----------------------------------------------------------------------
  // Pin gathering
  // ----------------------------------------------------------------------
  always_comb begin
    pin_raw.t1          = temp_past_cold_limit;
    pin_raw.t2          = temp_past_cool_zone;
    pin_raw.t3          = temp_past_warm_zone;
    pin_raw.t4          = temp_past_hot_limit;
    pin_raw.surge       = rect_surge;
    pin_raw.rect_ok     = rect_acceptable;
    pin_raw.ovp         = input_overvoltage;
    pin_raw.converged   = rect_converged;
    pin_raw.no_converge = rect_no_converge;
    pin_raw.ibat_low    = ibat_below_term;
    pin_raw.taper       = taper_phase;
    pin_raw.pre_to      = precharge_timeout;
    pin_raw.fast_to     = fastcharge_timeout;
    pin_raw.adapter     = adapter_present;
    pin_raw.ctrl_hi     = ctrl_pin_high;
    pin_raw.ctrl_lo     = ctrl_pin_low;
    pin_raw.die_hot     = die_overtemp;
    pin_raw.limit_short = current_limit_short;
    pin_raw.term_float  = term_pin_floating;
    pin_raw.prof_mod    = profile_modified;
  end

  // Only the second stage is ever looked at
  assign p = st_q.s2;

  // ----------------------------------------------------------------------
  // Temperature zone
  // ----------------------------------------------------------------------
  wcs_zone u_zone (
    .t1        (p.t1),
    .t2        (p.t2),
    .t3        (p.t3),
    .t4        (p.t4),
    .prof_mod  (p.prof_mod),
    .zone      (zone),
    .in_window (in_win),
    .cur_half  (z_half),
    .volt_red  (z_vred)
  );

  // ----------------------------------------------------------------------
  // Load modulator
  // ----------------------------------------------------------------------
  wcs_modtx #(
    .BIT_CYC (BIT_CYC)
  ) u_modtx (
    .clk     (clk),
    .reset_n (reset_n),
    .pk      (pk)
  );

  assign pk.req  = st_q.req;
  assign pk.hdr  = st_q.hdr;
  assign pk.data = st_q.data;

  // ----------------------------------------------------------------------
  // Reason selection
  // ----------------------------------------------------------------------
  // Fixed priority only decides ties within one cycle
  always_comb begin
    cand     = `WCS_RSN_UNKNOWN;
    cand_vld = 1'b1;
    if (p.adapter || p.ctrl_hi) begin
      cand = `WCS_RSN_UNKNOWN;
    end else if (p.die_hot || p.limit_short) begin
      cand = `WCS_RSN_FAULT;
    end else if (p.ctrl_lo || (st_q.state == WCS_ST_CHARGE && !in_win)) begin
      cand = `WCS_RSN_OVERTEMP;
    end else if (p.pre_to || p.fast_to) begin
      cand = `WCS_RSN_BATT_FAIL;
    end else if (p.no_converge) begin
      cand = `WCS_RSN_NO_RESP;
    end else if (st_q.state == WCS_ST_CHARGE && p.taper && p.ibat_low &&
                 !p.term_float) begin
      cand = `WCS_RSN_COMPLETE;
    end else begin
      cand_vld = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Supervisor next state
  // ----------------------------------------------------------------------
  assign active  = (st_q.state == WCS_ST_START) || (st_q.state == WCS_ST_WAIT_TEMP) ||
                   (st_q.state == WCS_ST_CHARGE);
  assign cep_due = st_q.cnt >= (st_q.fast ? `WCS_TMR_W'(CEP_FAST_CYC - 1) :
                                            `WCS_TMR_W'(CEP_SLOW_CYC - 1));

  always_comb begin
    st_d     = st_q;
    st_d.s1  = pin_raw;
    st_d.s2  = st_q.s1;
    st_d.req = 1'b0;
    // surge or overvoltage speeds packets
    // Set beats the settle clear in the same cycle
    st_d.fast = p.surge || p.ovp || (st_q.fast && !p.rect_ok);
    if (active && !st_q.rsn_vld && cand_vld) begin
      st_d.rsn_vld = 1'b1;
      st_d.reason  = cand;
    end
    // Interval timer saturates at the due count until an error packet is requested
    if (active && !cep_due) begin
      st_d.cnt = st_q.cnt + `WCS_TMR_W'(1);
    end
    if (active && cep_due && !pk.busy && !st_q.req && !st_q.rsn_vld) begin
      st_d.req  = 1'b1;
      st_d.hdr  = `WCS_HDR_CEP;
      st_d.data = rect_error;
      st_d.cnt  = '0;
    end
    case (st_q.state)
      WCS_ST_START: begin
        st_d.chg_en = 1'b0;
        if (p.converged) begin
          st_d.state = in_win ? WCS_ST_CHARGE : WCS_ST_WAIT_TEMP;
        end
      end
      WCS_ST_WAIT_TEMP: begin
        st_d.chg_en = 1'b0;
        if (in_win) begin
          st_d.state = WCS_ST_CHARGE;
        end
      end
      WCS_ST_CHARGE: begin
        st_d.chg_en = !p.ovp && in_win;
      end
      WCS_ST_END_SEND: begin
        st_d.chg_en = 1'b0;
        if (!st_q.end_sent && !pk.busy && !st_q.req) begin
          st_d.req      = 1'b1;
          st_d.hdr      = `WCS_HDR_END;
          st_d.data     = st_q.reason;
          st_d.end_sent = 1'b1;
        end else if (st_q.end_sent && pk.done) begin
          st_d.state = WCS_ST_OFF;
        end
      end
      WCS_ST_OFF: begin
        st_d.chg_en = 1'b0;
        st_d.hiz    = 1'b1;
      end
      default: begin
        st_d.state  = WCS_ST_START;
        st_d.chg_en = 1'b0;
      end
    endcase
    // A latched reason pre-empts every transfer state
    if (active && st_q.rsn_vld) begin
      st_d.state  = WCS_ST_END_SEND;
      st_d.chg_en = 1'b0;
    end
    st_d.cur_half = z_half && (st_d.state == WCS_ST_CHARGE);
    st_d.v_red    = z_vred && (st_d.state == WCS_ST_CHARGE);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign charge_enable          = st_q.chg_en;
  assign current_limit_half     = st_q.cur_half;
  assign voltage_target_reduced = st_q.v_red;
  assign comm_current_clamp     = pk.busy;
  assign output_high_z          = st_q.hiz;
  assign charge_status_output_val = 1'b0;
  assign charge_status_output_oe = st_q.chg_en;
  assign modulation_switch_a    = pk.mod_on;
  assign modulation_switch_b    = pk.mod_on;
  assign end_reason             = st_q.reason;
  assign end_reason_valid       = st_q.rsn_vld;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // enable only after convergence
  conv_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.chg_en) |-> $past(st_q.state) == WCS_ST_CHARGE ||
    $past(p.converged, 2)) else $error("charger enabled before convergence");

  temp_window_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.chg_en) |-> $past(in_win)) else $error("charge started out of window");

  cur_derate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_d.state == WCS_ST_CHARGE && !p.prof_mod &&
     (zone == WCS_Z_COOL || zone == WCS_Z_WARM)) |=> st_q.cur_half)
    else $error("current not halved");

  cur_full_a: assert property (@(posedge clk) disable iff (!reset_n)
    p.prof_mod |=> !st_q.cur_half) else $error("modified profile derated current");

  volt_warm_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_d.state == WCS_ST_CHARGE && zone == WCS_Z_WARM) |=> st_q.v_red)
    else $error("voltage not reduced in warm zone");

  ovp_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    p.ovp |=> !st_q.chg_en) else $error("output on during overvoltage");

  fast_cep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (active && st_q.fast && cep_due && !pk.busy && !st_q.req && !st_q.rsn_vld)
    |=> st_q.req && st_q.hdr == `WCS_HDR_CEP) else $error("error packet late");

  end_hdr_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.req && st_q.state == WCS_ST_END_SEND) |-> st_q.hdr == `WCS_HDR_END &&
    st_q.data == st_q.reason) else $error("end packet malformed");

  no_bad_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.rsn_vld |-> st_q.reason != `WCS_RSN_OVERVOLT &&
    st_q.reason != `WCS_RSN_OVERCUR && st_q.reason != `WCS_RSN_RECONFIG)
    else $error("forbidden reason code");

  reason_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.rsn_vld |=> st_q.rsn_vld && $stable(st_q.reason)) else $error("reason changed");

  off_park_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.state == WCS_ST_OFF |=> st_q.hiz && !st_q.chg_en) else $error("output not parked");

  // status pin follows enable, enable implies charging
  status_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
    charge_status_output_oe |-> st_q.state == WCS_ST_CHARGE ||
    $past(st_q.state) == WCS_ST_CHARGE) else $error("status on outside charging");
endmodule : wcs_top

// ===== rtl/wcs_zone.sv
`timescale 1ns/1ps
// Temperature zone decode; tN high means sensed voltage is past threshold N
module wcs_zone
  import wcs_pkg::*;
(
  input  wire logic t1,
  input  wire logic t2,
  input  wire logic t3,
  input  wire logic t4,
  input  wire logic prof_mod,
  output wcs_zone_t zone,
  output logic      in_window,
  output logic      cur_half,
  output logic      volt_red
);
  // --------------------------------------------------------------------
  // Zone decode
  // --------------------------------------------------------------------
  always_comb begin
    if (!t1 || t4) begin
      zone = WCS_Z_OUT;
    end else if (!t2) begin
      zone = WCS_Z_COOL;
    end else if (!t3) begin
      zone = WCS_Z_NORM;
    end else begin
      zone = WCS_Z_WARM;
    end
  end
  assign in_window = (zone != WCS_Z_OUT);
  assign cur_half  = !prof_mod && (zone == WCS_Z_COOL || zone == WCS_Z_WARM);
  assign volt_red  = (zone == WCS_Z_WARM);
endmodule : wcs_zone

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import wcs_pkg::*;
;
  localparam int FAST = 128;  // Short cadences keep the run brief
  localparam int SLOW = 400;
  localparam int BITC = 4;
  logic        clk, reset_n, en, half, vred, clamp, hiz, st_o, st_oe, sw_a, sw_b, erv;
  wcs_pins_t   p;           // All pin levels
  logic [7:0]  rect_error;  // Error byte
  logic [7:0]  rsn;         // Latched reason
  logic [23:0] rx;          // Last decoded frame
  int          fails, check_count, seed, frames, gap, perr;
  // Causes xored onto a charging pin set, and the reason each gives; the last (term float) must give no stop
  logic [19:0] mask [13] = '{20'h40, 20'h20, 20'h08, 20'h04, 20'h10, 20'h30000, 20'hc0000,
                             20'h100, 20'h80, 20'h800, 20'h600, 20'hc0, 20'h602};
  logic [7:0]  want [13] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03,
                             8'h06, 8'h06, 8'h08, 8'h01, 8'h00, 8'h00};
  wcs_top #(.CEP_FAST_CYC(FAST), .CEP_SLOW_CYC(SLOW), .BIT_CYC(BITC)) i_dut (
    .clk(clk), .reset_n(reset_n), .temp_past_cold_limit(p.t1), .temp_past_cool_zone(p.t2),
    .temp_past_warm_zone(p.t3), .temp_past_hot_limit(p.t4), .rect_surge(p.surge),
    .rect_acceptable(p.rect_ok), .input_overvoltage(p.ovp), .rect_converged(p.converged),
    .rect_no_converge(p.no_converge), .ibat_below_term(p.ibat_low), .taper_phase(p.taper),
    .precharge_timeout(p.pre_to), .fastcharge_timeout(p.fast_to), .adapter_present(p.adapter),
    .ctrl_pin_high(p.ctrl_hi), .ctrl_pin_low(p.ctrl_lo), .die_overtemp(p.die_hot),
    .current_limit_short(p.limit_short), .term_pin_floating(p.term_float),
    .profile_modified(p.prof_mod), .rect_error(rect_error), .charge_enable(en),
    .current_limit_half(half), .voltage_target_reduced(vred), .comm_current_clamp(clamp),
    .output_high_z(hiz), .charge_status_output_val(st_o), .charge_status_output_oe(st_oe),
    .modulation_switch_a(sw_a), .modulation_switch_b(sw_b), .end_reason(rsn),
    .end_reason_valid(erv));
  wcs_tx_model #(.BIT_CYC(BITC)) i_tx (.clk(clk), .reset_n(reset_n), .sw_a(sw_a),
    .sw_b(sw_b), .frame(clamp), .bits_q(rx), .frames_q(frames), .gap_q(gap),
    .pair_err_q(perr));
  // ----------------------
  // Bench tasks
  // ----------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : check
  task automatic stop_test;
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Inputs change only by NBA on the rising edge
  task automatic drive(input wcs_pins_t q, input logic rn);
    @(posedge clk);
    p <= q;
    reset_n <= rn;
  endtask : drive
  // Outputs read at the falling edge, well settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : step
  task automatic wait_frame;
    int f0;
    f0 = frames;
    for (int i = 0; i < 1500 && frames == f0; i++) @(negedge clk);
    if (frames == f0) begin
      fails++;
      stop_test;
    end
  endtask : wait_frame
  task automatic check_pkt(input logic [7:0] h, input logic [7:0] d);
    check(rx, {h ^ d, d, h});
  endtask : check_pkt
  function automatic wcs_pins_t run_pins();
    run_pins = '0;
    run_pins.t1 = 1'b1;
    run_pins.t2 = 1'b1;
    run_pins.converged = 1'b1;
  endfunction : run_pins
  // ----------------------
  // Clock and sequence
  // ----------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    wcs_pins_t q;
    int n;
    seed = 47360;
    fails = 0;
    check_count = 0;
    p = '0;
    reset_n = 1'b0;
    rect_error = 8'($random(seed));
    step(10);
    check({en, half, vred, clamp, hiz, st_o, st_oe, sw_a, sw_b, erv, rsn}, 0);
    q = run_pins();
    q.converged = 1'b0;
    drive(q, 1'b1);
    step(20);
    check(en, 0);
    q = run_pins() ^ 20'hc0000;
    drive(q, 1'b1);
    step(10);
    check(en, 0);
    drive(run_pins(), 1'b1);
    step(5);
    check({en, st_oe, st_o}, 3'b110);
    for (int m = 0; m < 6; m++) begin
      q = run_pins();
      q.prof_mod = m[0];
      q.t2 = (m / 2) != 0;
      q.t3 = (m / 2) == 2;
      drive(q, 1'b1);
      step(5);
      check({half, vred}, {!m[0] && (m / 2) != 1, (m / 2) == 2});
    end
    drive(run_pins(), 1'b1);
    repeat (3) wait_frame;
    check_pkt(8'h03, rect_error);
    check(gap >= SLOW - 2 && gap <= SLOW + 4, 1);
    q = run_pins();
    q.surge = 1'b1;
    drive(q, 1'b1);
    drive(run_pins(), 1'b1);
    repeat (3) wait_frame;
    check(gap >= FAST - 2 && gap <= FAST + 4, 1);
    q.surge = 1'b0;
    q.rect_ok = 1'b1;
    drive(q, 1'b1);
    repeat (3) wait_frame;
    check(gap >= SLOW - 2 && gap <= SLOW + 4, 1);
    q = run_pins();
    q.ovp = 1'b1;
    drive(q, 1'b1);
    step(5);
    check(en, 0);
    repeat (3) wait_frame;
    check({rx[7:0], 1'b1}, {8'h03, gap <= FAST + 4});
    for (int k = 0; k < 13; k++) begin
      // Model counters clear on reset, so look before each one
      check(perr, 0);
      drive('0, 1'b0);
      step(10);
      drive(run_pins(), 1'b1);
      rect_error <= 8'($random(seed));
      step(6 + ($random(seed) & 7));
      check(en, 1);
      drive(run_pins() ^ mask[k], 1'b1);
      if (k == 12) begin
        step(200);
        check(erv, 0);
      end else begin
        for (n = 0; n == 0 || (n < 4 && rx[7:0] !== 8'h02); n++) wait_frame;
        check_pkt(8'h02, want[k]);
        step(4);
        check({hiz, erv, rsn}, {2'b11, want[k]});
      end
    end
    check(perr, 0);
    stop_test;
  end
endmodule : testbench

// ===== sim/wcs_tx_model.sv
`timescale 1ns/1ps
// --------------------------------
// Transmitter side frame decoder
// --------------------------------
module wcs_tx_model #(
  parameter int BIT_CYC = 4
)
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  input  wire logic   sw_a,
  input  wire logic   sw_b,
  input  wire logic   frame,
  output logic [23:0] bits_q,
  output int          frames_q,
  output int          gap_q,
  output int          pair_err_q
);
  int   phase_q;  // Cycles into frame
  int   since_q;  // Cycles since last start
  logic prev_q;   // Frame marker delayed
  int   cur;      // Cycle index within frame
  // Index restarts on the first cycle the frame marker is seen
  assign cur = (frame && !prev_q) ? 0 : phase_q;
  // Mid-cell sampling, LSB first; mid-cell avoids edge skew
  // paired switch watch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits_q <= '0;
      frames_q <= 0;
      gap_q <= 0;
      pair_err_q <= 0;
      phase_q <= 0;
      since_q <= 0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= frame;
      phase_q <= cur + 1;
      since_q <= (frame && !prev_q) ? 1 : since_q + 1;
      // Start of frame: record spacing
      if (frame && !prev_q) begin
        gap_q <= since_q;
      end
      if (frame && (cur % BIT_CYC) == BIT_CYC / 2 && cur / BIT_CYC < 24) begin
        bits_q[cur / BIT_CYC] <= sw_a;
      end
      // Frame complete
      if (!frame && prev_q) begin
        frames_q <= frames_q + 1;
      end
      // Switches must agree and stay open outside frames
      if (sw_a !== sw_b || (sw_a && !frame)) begin
        pair_err_q <= pair_err_q + 1;
      end
    end
  end
endmodule : wcs_tx_model
